//--- common/mtimer_pkg.sv
// Constants, register map and carrier types of the match timer
package mtimer_pkg;

  // Register bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_TICK_SELECT_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_RUN_CONTROL = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_TRIGGER_MODE_CONTROL = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_TRIGGER_PIN_CONTROL = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_COUNT_VALUE = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_MATCH_VALUE = 3'h5;

  // Field positions in run_control
  localparam int RUN_REQUEST_BIT = 0;
  localparam int TRIGGER_ENABLE_BIT = 1;
  localparam int SAMPLE_CLOCK_SELECT_LO = 2;
  localparam int SAMPLE_CLOCK_SELECT_HI = 3;
  localparam int COUNTING_STATUS_BIT = 7;

  // Field positions in trigger_mode_control
  localparam int EXT_START_EN_BIT = 0;
  localparam int EXT_STOP_EN_BIT = 1;
  localparam int EDGE_MODE_LO = 4;
  localparam int EDGE_MODE_HI = 5;
  localparam int OUTPUT_POLARITY_BIT = 6;
  localparam int ONE_SHOT_BIT = 7;

  // Field positions in trigger_pin_control
  localparam int TRIGGER_PORT_SELECT_BIT = 3;
  localparam int PORT_A_PIN_COUNT = 3;

  // Reset values
  localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] MATCH_RESET = 8'h00;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [3:0] PIN_SEL_RESET = 4'h0;

  // Timing: log2 of tick and sample divisors of the system clock
  localparam int TICK_LOG2_0 = 0;
  localparam int TICK_LOG2_1 = 2;
  localparam int TICK_LOG2_2 = 4;
  localparam int TICK_LOG2_3 = 6;
  localparam int SAMPLE_LOG2_0 = 1;
  localparam int SAMPLE_LOG2_1 = 2;
  localparam int SAMPLE_LOG2_2 = 3;
  localparam int SAMPLE_LOG2_3 = 4;
  localparam int PRESCALE_W = 8;
  localparam int TRIGGER_PIN_COUNT = 11;

  // Status of the counter
  typedef enum logic {ST_STOPPED, ST_COUNTING} count_state_type;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // External trigger configuration
  typedef struct packed {
    logic enable;
    logic start_en;
    logic stop_en;
    logic [1:0] edge_mode;
    logic [3:0] pin_sel;
  } trig_cfg_type;

endpackage : mtimer_pkg

//--- verilog/tick_prescaler.sv
// Free-running prescaler giving the timer tick and the sampling strobe
`timescale 1ns/1ps
`default_nettype none

module tick_prescaler #(
  parameter int CNT_W = mtimer_pkg::PRESCALE_W
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic [1:0] i_tick_sel, // Tick divisor select
  input wire logic [1:0] i_sample_sel, // Sampling divisor select
  output logic o_tick_fall, // Falling edge of the tick
  output logic o_sample // Sampling strobe
);
  import mtimer_pkg::*;

  // Elaboration check: the divisor bits must fit in the counter
  if (CNT_W < TICK_LOG2_3 || CNT_W < SAMPLE_LOG2_3) begin : g_cnt_w_check
    $error("tick_prescaler: CNT_W too small");
  end

  // True when the low n bits are all ones
  function automatic logic low_ones(input logic [CNT_W-1:0] c, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < CNT_W; i++) begin
      if (i < n && !c[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction : low_ones

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d, samp_q, samp_d;
  int tick_n, samp_n;

  // Divisor lookup and strobe generation
  always_comb begin
    case (i_tick_sel)
      2'h0: tick_n = TICK_LOG2_0;
      2'h1: tick_n = TICK_LOG2_1;
      2'h2: tick_n = TICK_LOG2_2;
      default: tick_n = TICK_LOG2_3;
    endcase
    case (i_sample_sel)
      2'h0: samp_n = SAMPLE_LOG2_0;
      2'h1: samp_n = SAMPLE_LOG2_1;
      2'h2: samp_n = SAMPLE_LOG2_2;
      default: samp_n = SAMPLE_LOG2_3;
    endcase
    cnt_d = cnt_q + 1'b1;
    tick_d = low_ones(cnt_q, tick_n);
    samp_d = low_ones(cnt_q, samp_n);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
      samp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      samp_q <= samp_d;
    end
  end

  assign o_tick_fall = tick_q;
  assign o_sample = samp_q;

endmodule : tick_prescaler
`default_nettype wire

//--- verilog/trigger_filter.sv
// Pin synchroniser, selector and sampled noise filter for the trigger
`timescale 1ns/1ps
`default_nettype none

module trigger_filter #(
  parameter int N_PINS = mtimer_pkg::TRIGGER_PIN_COUNT
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic [N_PINS-1:0] i_pins, // Port A low, port B high
  input wire logic [3:0] i_pin_sel, // Trigger pin select
  input wire logic i_sample, // Sampling strobe
  output logic o_valid, // A pin is connected
  output logic o_rise, // Filtered rising edge
  output logic o_fall // Filtered falling edge
);
  import mtimer_pkg::*;

  // Elaboration check: the pin map is fixed at three A and eight B pins
  if (N_PINS != PORT_A_PIN_COUNT + 8) begin : g_pins_check
    $error("trigger_filter: N_PINS must be 11");
  end

  logic [N_PINS-1:0] meta_q, sync_q;
  logic samp_q, samp_d, filt_q, filt_d, rise_q, rise_d, fall_q, fall_d;
  logic sel_lvl, valid;

  // Two flops on every pin before anything looks at it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_pins;
      sync_q <= meta_q;
    end
  end

  // Reserved port A codes leave nothing connected
  always_comb begin
    if (i_pin_sel[TRIGGER_PORT_SELECT_BIT]) begin
      valid = 1'b1;
      sel_lvl = sync_q[PORT_A_PIN_COUNT + int'(i_pin_sel[2:0])];
    end else if (int'(i_pin_sel[2:0]) < PORT_A_PIN_COUNT) begin
      valid = 1'b1;
      sel_lvl = sync_q[i_pin_sel[1:0]];
    end else begin
      valid = 1'b0;
      sel_lvl = 1'b0;
    end
  end

  // Level accepted only when two samples in a row agree
  always_comb begin
    samp_d = samp_q;
    filt_d = filt_q;
    if (i_sample) begin
      samp_d = sel_lvl;
      if (samp_q == sel_lvl) begin
        filt_d = sel_lvl;
      end
    end
    rise_d = valid && filt_d && !filt_q;
    fall_d = valid && !filt_d && filt_q;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      samp_q <= 1'b0;
      filt_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      samp_q <= samp_d;
      filt_q <= filt_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign o_valid = valid;
  assign o_rise = rise_q;
  assign o_fall = fall_q;

endmodule : trigger_filter
`default_nettype wire

//--- verilog/match_timer_ext_trigger.sv
// 8-bit match timer with external start/stop trigger and toggle output
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module match_timer_ext_trigger (
  input wire logic i_clk_sys, // System clock, 100 MHz
  input wire logic i_rst, // Synchronous reset
  input wire mtimer_pkg::bus_req_type i_bus, // Register request
  input wire logic [mtimer_pkg::TRIGGER_PIN_COUNT-1:0] i_port_pin_level, // Pin
  output logic [mtimer_pkg::DATA_W-1:0] o_rdata, // Read data
  output logic o_match_interrupt, // Match pulse
  output logic o_toggle_output, // Toggle output
  output logic o_counting_status_flag // Counter running
);
  import mtimer_pkg::*;

  logic tick_fall, sample, pin_valid, pin_rise, pin_fall;
  logic start_edge, stop_edge, trig_ok, hit_match;
  count_state_type st_q, st_d;
  logic run_q, run_d, pend_q, pend_d, tog_q, tog_d, int_q, int_d;
  logic out_q, out_d;
  logic [DATA_W-1:0] cnt_q, cnt_d, match_q, match_d, rdata_q, rdata_d;
  logic [1:0] tick_sel_q, tick_sel_d, samp_sel_q, samp_sel_d;
  logic pol_q, pol_d, oneshot_q, oneshot_d;
  trig_cfg_type cfg_q, cfg_d;

  ////////////////////////////////////////////////////////////////////////////
  // Tick and sampling strobes, trigger pin filter

  tick_prescaler #(.CNT_W(PRESCALE_W)) u_presc (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick_sel(tick_sel_q),
    .i_sample_sel(samp_sel_q),
    .o_tick_fall(tick_fall),
    .o_sample(sample)
  );

  trigger_filter #(.N_PINS(TRIGGER_PIN_COUNT)) u_filt (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pins(i_port_pin_level),
    .i_pin_sel(cfg_q.pin_sel),
    .i_sample(sample),
    .o_valid(pin_valid),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // Edge mode decode: bit 0 picks start edge, bit 1 stop edge
  assign start_edge = cfg_q.edge_mode[0] ? pin_fall : pin_rise;
  assign stop_edge = cfg_q.edge_mode[1] ? pin_fall : pin_rise;
  assign trig_ok = cfg_q.enable && pin_valid;
  assign hit_match = (cnt_q == match_q);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and counter sequencing
  always_comb begin
    st_d = st_q;
    run_d = run_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    tog_d = tog_q;
    int_d = 1'b0;
    match_d = match_q;
    tick_sel_d = tick_sel_q;
    samp_sel_d = samp_sel_q;
    pol_d = pol_q;
    oneshot_d = oneshot_q;
    cfg_d = cfg_q;
    if (i_bus.wr) begin
      case (i_bus.addr)
        OFF_TICK_SELECT_CONTROL: tick_sel_d = i_bus.wdata[1:0];
        OFF_RUN_CONTROL: begin
          run_d = i_bus.wdata[RUN_REQUEST_BIT];
          cfg_d.enable = i_bus.wdata[TRIGGER_ENABLE_BIT];
          samp_sel_d =
            i_bus.wdata[SAMPLE_CLOCK_SELECT_HI:SAMPLE_CLOCK_SELECT_LO];
        end
        OFF_TRIGGER_MODE_CONTROL: begin
          cfg_d.start_en = i_bus.wdata[EXT_START_EN_BIT];
          cfg_d.stop_en = i_bus.wdata[EXT_STOP_EN_BIT];
          cfg_d.edge_mode = i_bus.wdata[EDGE_MODE_HI:EDGE_MODE_LO];
          pol_d = i_bus.wdata[OUTPUT_POLARITY_BIT];
          oneshot_d = i_bus.wdata[ONE_SHOT_BIT];
        end
        OFF_TRIGGER_PIN_CONTROL: cfg_d.pin_sel = i_bus.wdata[3:0];
        OFF_MATCH_VALUE: match_d = i_bus.wdata;
        default: ;
      endcase
    end
    // Counting happens only on the falling tick edge
    if (tick_fall) begin
      if (st_q == ST_STOPPED) begin
        if (run_q) begin
          st_d = ST_COUNTING;
        end
      end else if (pend_q) begin
        int_d = 1'b1;
        run_d = 1'b0;
        pend_d = 1'b0;
        st_d = ST_STOPPED;
      end else begin
        if (hit_match) begin
          cnt_d = '0;
          int_d = 1'b1;
          tog_d = ~tog_q;
          if (oneshot_q) begin
            run_d = 1'b0;
            st_d = ST_STOPPED;
          end
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
        if (!run_q) begin
          st_d = ST_STOPPED;
        end
      end
    end
    // Start only once fully stopped, stop only once running
    if (trig_ok && cfg_q.start_en && start_edge && st_q == ST_STOPPED) begin
      run_d = 1'b1;
    end
    // A stop edge on a tick cycle is kept; with a tick every clock
    // dropping it would lose every stop
    if (trig_ok && cfg_q.stop_en && stop_edge && st_q == ST_COUNTING &&
        run_q) begin
      pend_d = 1'b1;
    end
    if (st_d == ST_STOPPED) begin
      pend_d = 1'b0;
      tog_d = 1'b0;
    end
    // A counter write always wins over a tick in the same cycle
    if (i_bus.wr && i_bus.addr == OFF_COUNT_VALUE) begin
      cnt_d = '0;
    end
    out_d = tog_d ^ pol_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, stands one cycle after the read strobe
  always_comb begin
    rdata_d = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        OFF_TICK_SELECT_CONTROL: rdata_d = {6'h00, tick_sel_q};
        OFF_RUN_CONTROL: rdata_d = {st_q == ST_COUNTING, 3'h0, samp_sel_q,
                                    cfg_q.enable, run_q};
        OFF_TRIGGER_MODE_CONTROL: rdata_d = {oneshot_q, pol_q,
                                             cfg_q.edge_mode, 2'h0,
                                             cfg_q.stop_en, cfg_q.start_en};
        OFF_TRIGGER_PIN_CONTROL: rdata_d = {4'h0, cfg_q.pin_sel};
        OFF_COUNT_VALUE: rdata_d = cnt_q;
        OFF_MATCH_VALUE: rdata_d = match_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= ST_STOPPED;
      run_q <= 1'b0;
      pend_q <= 1'b0;
      cnt_q <= COUNT_RESET;
      tog_q <= 1'b0;
      int_q <= 1'b0;
      out_q <= 1'b0;
      match_q <= MATCH_RESET;
      tick_sel_q <= SEL_RESET;
      samp_sel_q <= SEL_RESET;
      pol_q <= 1'b0;
      oneshot_q <= 1'b0;
      cfg_q <= '{enable: 1'b0, start_en: 1'b0, stop_en: 1'b0,
                 edge_mode: 2'h0, pin_sel: PIN_SEL_RESET};
      rdata_q <= '0;
    end else begin
      st_q <= st_d;
      run_q <= run_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      tog_q <= tog_d;
      int_q <= int_d;
      out_q <= out_d;
      match_q <= match_d;
      tick_sel_q <= tick_sel_d;
      samp_sel_q <= samp_sel_d;
      pol_q <= pol_d;
      oneshot_q <= oneshot_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_match_interrupt = int_q;
  assign o_toggle_output = out_q;
  assign o_counting_status_flag = (st_q == ST_COUNTING);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic cnt_wr;
  assign cnt_wr = i_bus.wr && i_bus.addr == OFF_COUNT_VALUE;

  sequence s_first_edge;
    run_q && st_q == ST_STOPPED && tick_fall && !cnt_wr;
  endsequence

  first_edge_status_a: assert property (
    s_first_edge |=> st_q == ST_COUNTING && $stable(cnt_q))
    else $error("first tick edge did not only raise status");

  match_wrap_a: assert property (
    st_q == ST_COUNTING && tick_fall && hit_match && !pend_q && !cnt_wr
    |=> cnt_q == 8'h00 && o_match_interrupt)
    else $error("match did not zero counter and interrupt");

  toggle_flip_a: assert property (
    st_q == ST_COUNTING && run_q && !oneshot_q && !pend_q && tick_fall &&
    hit_match && !(i_bus.wr && i_bus.addr == OFF_TRIGGER_MODE_CONTROL)
    |=> o_toggle_output != $past(o_toggle_output))
    else $error("toggle output did not invert on match");

  stopped_toggle_a: assert property (
    st_q == ST_STOPPED |-> o_toggle_output == pol_q)
    else $error("toggle output not at rest level while stopped");

  final_count_a: assert property (
    st_q == ST_COUNTING && !run_q && tick_fall |=> st_q == ST_STOPPED)
    else $error("counter did not stop after final tick");

  count_clear_a: assert property (
    cnt_wr |=> cnt_q == 8'h00)
    else $error("counter write did not clear");

  one_shot_a: assert property (
    oneshot_q && st_q == ST_COUNTING && tick_fall && hit_match && !pend_q
    && !i_bus.wr |=> !run_q && st_q == ST_STOPPED)
    else $error("one-shot did not stop on match");

  ext_stop_a: assert property (
    pend_q && tick_fall && st_q == ST_COUNTING
    |=> o_match_interrupt && st_q == ST_STOPPED)
    else $error("external stop did not interrupt and stop");

  ext_start_a: assert property (
    trig_ok && cfg_q.start_en && start_edge && st_q == ST_STOPPED
    |=> run_q)
    else $error("external start did not set run request");

  // Trigger edges are ignored until the status flag has settled
  ext_stop_take_a: assert property (
    trig_ok && cfg_q.stop_en && stop_edge && st_q == ST_COUNTING && run_q
    |=> pend_q || !o_counting_status_flag)
    else $error("external stop edge was not taken");

  late_start_a: assert property (
    st_q == ST_COUNTING && !run_q && !i_bus.wr |=> !run_q)
    else $error("start accepted before counting stopped");

  early_stop_a: assert property (
    st_q == ST_STOPPED |=> !pend_q)
    else $error("stop accepted before counting began");

  // Counter steps only on ticks while counting
  count_step_a: assert property (
    st_q == ST_COUNTING && tick_fall && !hit_match && !pend_q && !cnt_wr
    |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not step on tick");

  count_hold_a: assert property (
    st_q == ST_STOPPED && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  stopped_quiet_a: assert property (
    st_q == ST_STOPPED |=> !o_match_interrupt)
    else $error("interrupt raised while stopped");

endmodule : match_timer_ext_trigger
`default_nettype wire

//--- verification/trigger_src.sv
// Far-side model: trigger pulse source on the selected port pin
`timescale 1ns/1ps
`default_nettype none

module trigger_src (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_go, // Start one pulse
  input wire logic i_idle, // Idle level of the pin
  input wire logic [7:0] i_len, // Pulse length in clocks
  input wire logic [3:0] i_idx, // Driven pin index
  output logic [10:0] o_pins // Port pin levels
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic alt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse length counter; lengths chosen by the bench avoid the marginal band
  always_comb begin
    cnt_d = cnt_q;
    if (i_go) begin
      cnt_d = i_len;
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
      alt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      alt_q <= ~alt_q;
    end
  end

  // Unselected pins toggle every cycle so a wrong pin choice shows up
  always_comb begin
    for (int k = 0; k < 11; k++) begin
      o_pins[k] = alt_q ^ k[0];
    end
    o_pins[i_idx] = i_idle ^ (cnt_q != 8'h00);
  end
endmodule : trigger_src

`default_nettype wire

//--- verification/tb_match_timer_ext_trigger.sv
// Self-checking bench of the match timer with external trigger
`timescale 1ns/1ps
`default_nettype none

module tb_match_timer_ext_trigger;
  import mtimer_pkg::*;

  typedef struct packed {
    logic [2:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } row_type;

  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  bus_req_type i_bus = '0;
  logic [10:0] pins;
  logic [7:0] o_rdata;
  logic o_match_interrupt;
  logic o_toggle_output;
  logic o_counting_status_flag;
  logic go = 1'b0;
  logic idle = 1'b0;
  logic [7:0] len = 8'h00;
  int seen_int = 0;
  logic t0;
  logic [7:0] c;
  logic [7:0] g;
  int errors = 0;
  int n_tests = 0;
  int n;
  bit stops;
  // Reserved bits and read-only places read back masked
  row_type rows [8] = '{
    '{3'h0, 8'hff, 8'h03}, '{3'h1, 8'h7e, 8'h0e},
    '{3'h2, 8'hff, 8'hf3}, '{3'h3, 8'hff, 8'h0f},
    '{3'h4, 8'hff, 8'h00}, '{3'h5, 8'ha5, 8'ha5},
    '{3'h6, 8'hff, 8'h00}, '{3'h7, 8'hff, 8'h00}};

  match_timer_ext_trigger match_timer_ext_trigger_i (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_bus(i_bus),
    .i_port_pin_level(pins),
    .o_rdata(o_rdata),
    .o_match_interrupt(o_match_interrupt),
    .o_toggle_output(o_toggle_output),
    .o_counting_status_flag(o_counting_status_flag)
  );

  trigger_src trigger_src_i (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_go(go),
    .i_idle(idle),
    .i_len(len),
    .i_idx(4'h5),
    .o_pins(pins)
  );

  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Running count of match interrupt pulses, one driver only
  always @(posedge i_clk_sys) begin
    if (o_match_interrupt === 1'b1) begin
      seen_int <= seen_int + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    i_bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    i_bus.rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // Bounded wait on the interrupt (s=0) or the status flag (s=1)
  task wait_on(input bit s, input logic v, output int k);
    k = 0;
    do begin
      @(posedge i_clk_sys);
      #1 k++;
    end while ((s ? o_counting_status_flag : o_match_interrupt) !== v
               && k < 500);
    if (k >= 500) begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report();
    end
  endtask : wait_on

  task pulse(input logic [7:0] l);
    @(posedge i_clk_sys);
    len <= l;
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    repeat (l + 30) @(posedge i_clk_sys);
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, c);
      check(c, rows[i].r);
    end
    $display("test register access done");
    // Second reset in mid-run restores every register
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], c);
      check(c, 8'h00);
    end
    check(o_toggle_output, 1'b0);
    $display("test reset done");
    // Period with tick every 4 clocks and match value 2
    wr(3'h5, 8'h02);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h01);
    wait_on(1'b1, 1'b1, n);
    check(n <= 4 && o_counting_status_flag, 1'b1);
    wait_on(1'b0, 1'b1, n);
    t0 = o_toggle_output;
    wait_on(1'b0, 1'b1, n);
    check(n, 12);
    check(o_toggle_output, !t0);
    wait_on(1'b0, 1'b1, n);
    check(n, 12);
    wr(3'h1, 8'h00);
    wait_on(1'b1, 1'b0, n);
    check(n <= 10, 1'b1);
    check(o_toggle_output, 1'b0);
    wr(3'h2, 8'h40);
    repeat (2) @(posedge i_clk_sys);
    check(o_toggle_output, 1'b1);
    wr(3'h2, 8'h00);
    $display("test period done");
    // Resume keeps the count; a write clears it
    wr(3'h5, 8'hff);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h01);
    repeat (10) @(posedge i_clk_sys);
    wr(3'h1, 8'h00);
    wait_on(1'b1, 1'b0, n);
    rd(3'h4, c);
    wr(3'h1, 8'h01);
    wait_on(1'b1, 1'b1, n);
    rd(3'h4, g);
    check((g - c) <= 8'h02 && c != 8'h00, 1'b1);
    wr(3'h1, 8'h00);
    wait_on(1'b1, 1'b0, n);
    wr(3'h4, 8'h55);
    rd(3'h4, c);
    check(c, 8'h00);
    $display("test resume done");
    // One-shot stops itself after the match
    wr(3'h5, 8'h04);
    wr(3'h2, 8'h80);
    wr(3'h1, 8'h01);
    wait_on(1'b0, 1'b1, n);
    wait_on(1'b1, 1'b0, n);
    check(n <= 2, 1'b1);
    rd(3'h1, c);
    check(c, 8'h00);
    $display("test one-shot done");
    // Trigger disabled: a long pulse must not start the timer
    wr(3'h5, 8'hff);
    wr(3'h3, 8'h0a);
    wr(3'h2, 8'h23);
    pulse(8'd40);
    check(o_counting_status_flag, 1'b0);
    // Reserved port A code: the pulse on pin 5 must not reach the timer
    wr(3'h3, 8'h05);
    wr(3'h1, 8'h02);
    pulse(8'd40);
    check(o_counting_status_flag, 1'b0);
    wr(3'h3, 8'h0a);
    // Every edge mode with short and long pulses
    for (int m = 0; m < 4; m++) begin
      wr(3'h1, 8'h00);
      wr(3'h2, {2'b00, m[1:0], 4'h3});
      idle <= m[0];
      repeat (20) @(posedge i_clk_sys);
      wr(3'h1, 8'h02);
      pulse(8'd1);
      check(o_counting_status_flag, 1'b0);
      n = seen_int;
      pulse(8'd40);
      stops = m[1] != m[0];
      check(o_counting_status_flag, !stops);
      check(seen_int != n, stops);
      wr(3'h1, 8'h02);
      wait_on(1'b1, 1'b0, n);
      wr(3'h4, 8'h00);
    end
    $display("test external trigger done");
    final_report();
  end
endmodule : tb_match_timer_ext_trigger

`default_nettype wire
